// *** rtl/lcd_pkg.sv ***
package lcd_pkg;
    // ********************************************************
    // Register map and field layout
    // ********************************************************
    localparam logic [7:0] MODE_REG_ADDR = 8'hdc;
    localparam logic [7:0] RAM_FIRST_ADDR = 8'he0;
    localparam logic [7:0] RAM_LAST_ADDR = 8'hf7;
    localparam int RAM_BYTES = 24;
    localparam int BYTES_PER_COM = 6;
    localparam int SEG_COUNT = 45;
    localparam int COM_COUNT = 4;
    localparam int SEG_FIRST_BIT = 3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int DRV_LSB = 0;
    localparam int PRE_LSB = 3;
    localparam int DUTY_LSB = 6;

    // ********************************************************
    // Field encodings
    // ********************************************************
    localparam logic [2:0] PRE_OFF = 3'h0;
    localparam logic [2:0] PRE_STANDBY = 3'h1;
    localparam logic [2:0] PRE_BAD_A = 3'h2;
    localparam logic [2:0] PRE_DIV32 = 3'h3;
    localparam logic [2:0] PRE_DIV64 = 3'h4;
    localparam logic [2:0] PRE_DIV128 = 3'h5;
    localparam logic [2:0] PRE_DIV256 = 3'h6;
    localparam logic [2:0] PRE_BAD_B = 3'h7;
    localparam logic [2:0] DRV_BAD = 3'h7;
    localparam logic [1:0] DUTY_QUARTER = 2'h0;
    localparam logic [1:0] DUTY_STATIC = 2'h1;
    localparam logic [1:0] DUTY_HALF = 2'h2;
    localparam logic [1:0] DUTY_THIRD = 2'h3;

    // Reference ticks per drive-frequency step, 32768 Hz divided
    // down to 64, 85, 128, 171, 256, 341 and 512 Hz.
    localparam logic [9:0] DRV_DIV [7] = '{10'h200, 10'h180, 10'h100,
        10'h0c0, 10'h080, 10'h060, 10'h040};

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int LOWZ_REF_TICKS = 8;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int MISSING_TIMEOUT_NS = 100000;
    localparam int MISSING_CYCLES = MISSING_TIMEOUT_NS / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {
        SCAN_OFF = 2'b01,
        SCAN_RUN = 2'b10
    } scan_state_t;
endpackage

// *** rtl/ref_clock_if.sv ***
interface ref_clock_if;
    logic [2:0] prescale_sel;
    logic stop_mode;
    logic standby_edge;
    logic ref_tick;
    logic clock_missing;
    modport gen (input prescale_sel, input stop_mode, input standby_edge,
        output ref_tick, output clock_missing);
    modport user (output prescale_sel, output stop_mode,
        output standby_edge, input ref_tick, input clock_missing);
endinterface

// *** rtl/lcd_ref_clock.sv ***
module lcd_ref_clock
    import lcd_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    ref_clock_if.gen rc
);
    logic [7:0] pre_cnt;
    logic [11:0] idle_cnt;
    logic [8:0] pre_div;
    logic main_sel;
    logic main_tick;
    logic next_tick;

    // Divisor of the main oscillator for each prescale code.
    assign pre_div = (rc.prescale_sel == PRE_DIV32) ? 9'h020 :
        (rc.prescale_sel == PRE_DIV64) ? 9'h040 :
        (rc.prescale_sel == PRE_DIV128) ? 9'h080 : 9'h100;
    assign main_sel = (rc.prescale_sel >= PRE_DIV32)
        && (rc.prescale_sel <= PRE_DIV256);
    // The main oscillator gives no pulses while the core is stopped.
    assign main_tick = main_sel && !rc.stop_mode
        && ({1'b0, pre_cnt} == pre_div - 9'h001);
    // Standby source bypasses the prescaler entirely.
    assign next_tick = (rc.prescale_sel == PRE_STANDBY) ? rc.standby_edge
        : main_tick;

    // Prescale counter and clock supervisor watchdog.
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            pre_cnt <= 8'h00;
            idle_cnt <= 12'h000;
            rc.ref_tick <= 1'b0;
            rc.clock_missing <= 1'b0;
        end
        else
        begin
            pre_cnt <= (main_tick || !main_sel) ? 8'h00 : pre_cnt + 8'h01;
            rc.ref_tick <= next_tick;
            if (next_tick || rc.prescale_sel == PRE_OFF)
            begin
                idle_cnt <= 12'h000;
            end
            else if (idle_cnt != 12'(MISSING_CYCLES))
            begin
                idle_cnt <= idle_cnt + 12'h001;
            end
            rc.clock_missing <= (idle_cnt == 12'(MISSING_CYCLES));
        end
    end
endmodule

// *** rtl/lcd_multiplex_driver.sv ***
// How it works
// - 24-byte display memory drives 45 segment and 4 common outputs.
// - Mode/control register sits at DCh; bits 7:6 pick multiplex mode.
// - Duty 00 four commons, 01 one, 10 two, 11 three.
// - Bits 5:3 prescale, with bits 2:0 set frequencies or display off.
// - Prescale 000 off, 001 standby, 011-110 divide 32-256; 010/111 bad.
// - Drive field picks 64 to 512 Hz; code 111 unused.
// - Frame rate is drive rate divided by active common count.
// - Display off drives every segment and common output low.
// - Scan reads memory itself; unused bytes stay ordinary storage.
// - Register writes land in a shadow, applied at frame end, or at once while the scan is halted.
// - Standby setting clocks the display from the standby oscillator.
// - Supervisor may blank display on a slow reference clock.
// - Low-impedance divider on for 8 reference ticks per drive edge.
// - High-impedance divider on while running with a reference clock; low only at changes.
// - Display off disconnects the whole bias network.
// - Set bit lights element; E0h-F7h hold six bytes per common.
// - Reset clears mode register; memory content undefined.
// - Missing display clock grounds all segment and common lines.
module lcd_multiplex_driver
    import lcd_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic stop_in,
    input wire logic standby_osc_in,
    output logic [7:0] rdata_out,
    output logic [SEG_COUNT-1:0] seg_out,
    output logic [COM_COUNT-1:0] com_out,
    output logic bias_high_en_out,
    output logic bias_low_en_out
);
    // ********************************************************
    // Storage and state
    // ********************************************************
    logic [7:0] ram [RAM_BYTES];
    logic [7:0] shadow_mode;
    logic [7:0] active_mode;
    scan_state_t state;
    scan_state_t next_state;
    logic [9:0] drv_cnt;
    logic [1:0] com_idx;
    logic [3:0] lowz_cnt;
    logic sb_meta;
    logic sb_sync;
    logic sb_last;

    ref_clock_if rc ();

    lcd_ref_clock ref_clock_u (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .rc(rc)
    );

    // ********************************************************
    // Decode
    // ********************************************************
    logic [1:0] duty;
    logic [2:0] pre;
    logic [2:0] drv;
    logic cfg_valid;
    logic [1:0] last_com;
    logic [9:0] drv_div;
    logic ram_hit;
    logic [4:0] ram_idx;
    logic mode_hit;
    logic drive_edge;
    logic frame_end;
    logic load_cfg;
    logic running;
    logic lit;
    logic [7:0] read_val;
    logic [47:0] row;

    // Active configuration fields.
    assign duty = active_mode[DUTY_LSB +: 2];
    assign pre = active_mode[PRE_LSB +: 3];
    assign drv = active_mode[DRV_LSB +: 3];
    assign cfg_valid = (pre != PRE_OFF) && (pre != PRE_BAD_A)
        && (pre != PRE_BAD_B) && (drv != DRV_BAD);
    // Index of the last active common line.
    assign last_com = (duty == DUTY_STATIC) ? 2'h0 :
        (duty == DUTY_HALF) ? 2'h1 :
        (duty == DUTY_THIRD) ? 2'h2 : 2'h3;
    assign drv_div = (drv == DRV_BAD) ? DRV_DIV[0] : DRV_DIV[drv];

    // Data-space address decode.
    assign mode_hit = (addr_in == MODE_REG_ADDR);
    assign ram_hit = (addr_in >= RAM_FIRST_ADDR)
        && (addr_in <= RAM_LAST_ADDR);
    assign ram_idx = 5'(addr_in - RAM_FIRST_ADDR);
    assign read_val = mode_hit ? shadow_mode :
        (ram_hit ? ram[ram_idx] : 8'h00);

    // Scan timing: one common step per drive period.
    assign running = (state == SCAN_RUN);
    assign drive_edge = running && rc.ref_tick
        && (drv_cnt == drv_div - 10'h001);
    assign frame_end = drive_edge && (com_idx == last_com);
    // A halted scan has no frames, so a new setting goes in at once.
    assign load_cfg = !running || frame_end;
    assign lit = running && !rc.clock_missing;

    // Row of the current common: six bytes, bit n drives seg_out bit n-3.
    genvar gi;
    generate
        for (gi = 0; gi < BYTES_PER_COM; gi = gi + 1)
        begin : g_row
            assign row[gi*8 +: 8] =
                ram[5'(int'(com_idx) * BYTES_PER_COM + gi)];
        end
    endgenerate

    assign next_state = cfg_valid ? SCAN_RUN : SCAN_OFF;

    // Reference pulses to the clock generator.
    assign rc.prescale_sel = pre;
    assign rc.stop_mode = stop_in;
    assign rc.standby_edge = sb_sync && !sb_last;

    // ********************************************************
    // Standby oscillator synchroniser
    // ********************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            sb_meta <= 1'b0;
            sb_sync <= 1'b0;
            sb_last <= 1'b0;
        end
        else
        begin
            sb_meta <= standby_osc_in;
            sb_sync <= sb_meta;
            sb_last <= sb_sync;
        end
    end

    // ********************************************************
    // Register and memory access
    // ********************************************************
    // Display memory has no reset; its content is undefined.
    always_ff @(posedge clock_in)
    begin
        if (write_in && ram_hit)
        begin
            ram[ram_idx] <= wdata_in;
        end
    end

    // Shadow register, active copy and read data.
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            shadow_mode <= MODE_RESET;
            active_mode <= MODE_RESET;
            rdata_out <= 8'h00;
        end
        else
        begin
            if (write_in && mode_hit)
            begin
                shadow_mode <= wdata_in;
            end
            if (load_cfg)
            begin
                active_mode <= shadow_mode;
            end
            rdata_out <= read_in ? read_val : 8'h00;
        end
    end

    // ********************************************************
    // Scan sequencer
    // ********************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            state <= SCAN_OFF;
            drv_cnt <= 10'h000;
            com_idx <= 2'h0;
            lowz_cnt <= 4'h0;
        end
        else
        begin
            case (state)
                SCAN_RUN:
                begin
                    if (rc.ref_tick)
                    begin
                        drv_cnt <= drive_edge ? 10'h000 : drv_cnt + 10'h001;
                    end
                    if (drive_edge)
                    begin
                        com_idx <= frame_end ? 2'h0 : com_idx + 2'h1;
                        lowz_cnt <= 4'(LOWZ_REF_TICKS);
                    end
                    else if (rc.ref_tick && lowz_cnt != 4'h0)
                    begin
                        lowz_cnt <= lowz_cnt - 4'h1;
                    end
                end
                default:
                begin
                    drv_cnt <= 10'h000;
                    com_idx <= 2'h0;
                    lowz_cnt <= 4'h0;
                end
            endcase
            state <= next_state;
        end
    end

    // ********************************************************
    // Panel outputs
    // ********************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            seg_out <= '0;
            com_out <= '0;
            bias_high_en_out <= 1'b0;
            bias_low_en_out <= 1'b0;
        end
        else
        begin
            seg_out <= lit ? row[SEG_FIRST_BIT +: SEG_COUNT] : '0;
            com_out <= lit ? 4'(4'h1 << com_idx) : '0;
            bias_high_en_out <= lit;
            bias_low_en_out <= lit && (lowz_cnt != 4'h0);
        end
    end
endmodule

// *** sim/lcd_multiplex_driver_monitor.sv ***
module lcd_check
    import lcd_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [7:0] rdata_out,
    input wire logic [SEG_COUNT-1:0] seg_out,
    input wire logic [COM_COUNT-1:0] com_out,
    input wire logic bias_high_en_out,
    input wire logic bias_low_en_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Port checks
    // ****************
    logic [7:0] shadow;
    wire hit = addr_in == MODE_REG_ADDR;
    wire mem = addr_in >= RAM_FIRST_ADDR && addr_in <= RAM_LAST_ADDR;
    wire lit = bias_high_en_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    // Keeps the last value written to the mode register.
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            shadow <= MODE_RESET;
        else if (write_in && hit)
            shadow <= wdata_in;
    end

    a_read_mode: assert property (read_in && hit && !write_in |=>
        rdata_out == shadow) else $error("mode read mismatch");
    a_read_other: assert property (read_in && !hit && !mem |=>
        rdata_out == 8'h00) else $error("unmapped read not zero");
    a_off_blank: assert property (!lit |-> seg_out == '0 &&
        com_out == '0 && !bias_low_en_out) else $error("dark not blank");
    a_com_onehot: assert property (lit |->
        $onehot(com_out)) else $error("common not one-hot");
    a_com_order: assert property (lit && $past(lit) &&
        $changed(com_out) |-> com_out == 4'h1 ||
        com_out == $past(com_out) << 1) else $error("common order");
    a_edge_pulse: assert property (lit && $past(lit) &&
        $changed(com_out) |-> ##[0:1] bias_low_en_out)
        else $error("no low divider at drive edge");
    a_low_lit: assert property (bias_low_en_out |->
        lit) else $error("low divider while dark");
    a_seg_stands: assert property (lit && $past(lit) &&
        $changed(seg_out) |-> ##[0:1] bias_low_en_out)
        else $error("segments moved off a drive edge");
endmodule

bind lcd_multiplex_driver lcd_check i_check (.clock_in(clock_in),
    .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .seg_out(seg_out), .com_out(com_out),
    .bias_high_en_out(bias_high_en_out),
    .bias_low_en_out(bias_low_en_out));

// *** sim/lcd_glass_panel.sv ***
module lcd_glass_panel
    import lcd_pkg::*;
(
    input wire logic clock_in,
    input wire logic [SEG_COUNT-1:0] seg_in,
    input wire logic [COM_COUNT-1:0] com_in,
    output logic [SEG_COUNT-1:0] img_out [COM_COUNT]
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Passive glass
    // ****************
    // Each backplane keeps the elements shown while it is driven.
    always_ff @(posedge clock_in)
    begin
        for (int c = 0; c < COM_COUNT; c++)
            if (com_in[c])
                img_out[c] <= seg_in;
    end
endmodule

// *** sim/lcd_multiplex_driver_bench.sv ***
module lcd_multiplex_driver_bench
    import lcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Bench
    // ****************
    logic clock_in, rstn_in, write_in, read_in, stop_in, standby_osc_in;
    logic [7:0] addr_in, wdata_in, rdata_out, pend;
    logic [SEG_COUNT-1:0] seg_out;
    logic [COM_COUNT-1:0] com_out;
    logic bias_high_en_out, bias_low_en_out;
    logic [SEG_COUNT-1:0] img [COM_COUNT];
    logic [7:0] ram [RAM_BYTES];
    logic [7:0] bad [4] = '{{DUTY_STATIC, PRE_BAD_A, 3'h6},
        {DUTY_STATIC, PRE_BAD_B, 3'h6}, {DUTY_STATIC, PRE_DIV32, DRV_BAD},
        {DUTY_STATIC, PRE_OFF, 3'h6}};
    logic [31:0] rnd = 32'hd319d594;
    int failures, check_count, cur, n, sb_run, k;
    time t0;

    lcd_multiplex_driver i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
        .read_in(read_in), .stop_in(stop_in),
        .standby_osc_in(standby_osc_in), .rdata_out(rdata_out),
        .seg_out(seg_out), .com_out(com_out),
        .bias_high_en_out(bias_high_en_out),
        .bias_low_en_out(bias_low_en_out));
    lcd_glass_panel i_panel (.clock_in(clock_in), .seg_in(seg_out),
        .com_in(com_out), .img_out(img));

    // Main clock, and a time-compressed standby oscillator.
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    initial
    begin
        standby_osc_in = 1'b0;
        forever #100 standby_osc_in = sb_run ? ~standby_osc_in : 1'b0;
    end

    // Model helpers: random bytes, active commons, ref ticks, rows.
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int ncom(logic [7:0] m);
        return m[7:6] == DUTY_QUARTER ? 4 : int'(m[7:6]);
    endfunction
    function automatic int tck(logic [2:0] p);
        return p == PRE_STANDBY ? 4 : 32 << (p - 3);
    endfunction
    function automatic logic [47:0] row(int c);
        return {ram[c*6+5], ram[c*6+4], ram[c*6+3], ram[c*6+2],
            ram[c*6+1], ram[c*6]} >> 3;
    endfunction

    // Compares, counts and ends the run.
    task automatic chk(input string s, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Waits for the high (hi set) or low divider enable to reach v.
    task automatic hold(input bit hi, input logic v, input int lim);
        logic s;
        s = hi ? bias_high_en_out : bias_low_en_out;
        for (k = 0; k < lim && s !== v; k++)
        begin
            @(negedge clock_in);
            s = hi ? bias_high_en_out : bias_low_en_out;
        end
        if (s !== v)
        begin
            failures++;
            results();
        end
    endtask

    // Register cycles on the data-space strobes.
    task automatic wr(input logic [7:0] a, d);
        @(negedge clock_in);
        addr_in = a;
        wdata_in = d;
        write_in = 1'b1;
        @(negedge clock_in);
        write_in = 1'b0;
        if (a == MODE_REG_ADDR)
            pend = d;
        else if (a >= RAM_FIRST_ADDR && a <= RAM_LAST_ADDR)
            ram[a - RAM_FIRST_ADDR] = d;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clock_in);
        addr_in = a;
        read_in = 1'b1;
        @(negedge clock_in);
        read_in = 1'b0;
        chk("rdata", rdata_out, e);
    endtask

    // Waits for one drive edge and checks it against the scan model.
    task automatic step(input int ticks, tk);
        hold(1'b0, 1'b0, 20000);
        hold(1'b0, 1'b1, 20000);
        // Up to three clocks of synchroniser and prescaler start-up
        // latency may be missing from the whole reference ticks.
        if (ticks > 0)
            chk("ticks", (($time - t0) / 50 + 3) / tk, ticks);
        t0 = $time;
        if (cur == n - 1)
        begin
            n = ncom(pend);
            cur = 0;
        end
        else
            cur++;
        @(negedge clock_in);
        chk("com", com_out, 1 << cur);
        chk("seg", seg_out, row(cur));
        chk("panel", img[cur], row(cur));
    endtask
    task automatic on(input logic [7:0] m);
        wr(MODE_REG_ADDR, m);
        hold(1'b1, 1'b1, 20000);
        n = ncom(m);
        cur = 0;
        t0 = $time;
        chk("first com", com_out, 1);
    endtask
    task automatic dark(input int lim);
        hold(1'b1, 1'b0, lim);
        @(negedge clock_in);
        chk("dark", {seg_out, com_out, bias_low_en_out}, 0);
    endtask

    // Main sequence.
    initial
    begin
        {rstn_in, write_in, read_in, stop_in} = 4'h0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        repeat (8) @(negedge clock_in);
        rstn_in = 1'b1;
        chk("reset", {seg_out, com_out, bias_high_en_out}, 0);
        rd(MODE_REG_ADDR, 8'h00);
        for (int a = 0; a < RAM_BYTES; a++)
        begin
            rnd = lfsr(rnd);
            wr(RAM_FIRST_ADDR + 8'(a), rnd[7:0]);
        end
        wr(8'hf8, 8'h5a);
        for (int a = 0; a < RAM_BYTES; a++)
            rd(RAM_FIRST_ADDR + 8'(a), ram[a]);
        rd(8'hf8, 8'h00);
        rd(8'hdd, 8'h00);
        wr(MODE_REG_ADDR, 8'h97);
        rd(MODE_REG_ADDR, 8'h97);
        dark(10);
        $display("test registers done");
        sb_run = 1;
        stop_in = 1'b1;
        on({DUTY_QUARTER, PRE_STANDBY, 3'h6});
        foreach (bad[d])
        begin
            wr(MODE_REG_ADDR, {2'(3 - d), PRE_STANDBY, 3'h6});
            rd(MODE_REG_ADDR, pend);
            repeat (5) step(64, 4);
        end
        $display("test duty done");
        for (int d = 0; d < 7; d++)
        begin
            wr(MODE_REG_ADDR, {DUTY_STATIC, PRE_STANDBY, 3'(d)});
            // The first switch waits for the quarter-duty frame to end.
            repeat (d == 0 ? 4 : 1) step(0, 4);
            step(DRV_DIV[d], 4);
        end
        sb_run = 0;
        dark(2500);
        sb_run = 1;
        hold(1'b1, 1'b1, 3000);
        $display("test drive and supervisor done");
        stop_in = 1'b0;
        for (int p = 3; p < 7; p++)
        begin
            wr(MODE_REG_ADDR, {DUTY_STATIC, 3'(p), 3'h6});
            step(0, 4);
            step(64, tck(3'(p)));
            for (k = 0; bias_low_en_out === 1'b1 && k < 9000; k++)
                @(negedge clock_in);
            chk("low width", k, LOWZ_REF_TICKS * tck(3'(p)) - 1);
        end
        foreach (bad[i])
        begin
            wr(MODE_REG_ADDR, bad[i]);
            dark(20000);
            on({DUTY_STATIC, PRE_DIV32, 3'h6});
        end
        $display("test prescale and off done");
        results();
    end
endmodule
